// File: dmp_pkg.sv
/*
 * Shared constants for the DMA channel parameter readback block: register
 * offsets, field positions, field default codes, bus answer codes and the
 * handshake state encoding.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package dmp_pkg;

  // Byte addresses of the two 32-bit halves of the 64-bit register
  localparam logic [11:0] DMP_PARAMS_TWO_LO_OFS = 12'h3E8;
  localparam logic [11:0] DMP_PARAMS_TWO_HI_OFS = 12'h3EC;

  // Field positions within the 64-bit word
  localparam int DMP_CHAN2_KIND_LSB = 40;
  localparam int DMP_CHAN1_KIND_LSB = 36;
  localparam int DMP_CHAN0_KIND_LSB = 32;
  localparam int DMP_DEPTH_LSB = 28;
  localparam int DMP_BURST_LSB = 16;
  localparam int DMP_FLOW_LSB = 14;
  localparam int DMP_FIXED_LIST_BIT = 13;
  localparam int DMP_WRITEBACK_BIT = 12;
  localparam int DMP_MULTIBLOCK_BIT = 11;
  localparam int DMP_LOCK_BIT = 10;
  localparam int DMP_GATHER_BIT = 9;
  localparam int DMP_SCATTER_BIT = 8;
  localparam int DMP_SRC_WIDTH_LSB = 3;
  localparam int DMP_DST_WIDTH_LSB = 0;

  typedef enum logic [3:0] {
    not_fixed = 4'h0,
    contiguous_then_reload = 4'h1,
    reload_then_contiguous = 4'h2,
    reload_both = 4'h3,
    contiguous_then_list = 4'h4,
    reload_then_list = 4'h5,
    list_then_contiguous = 4'h6,
    list_then_reload = 4'h7,
    list_both = 4'h8
  } dmp_multiblock_kind_type;

  typedef enum logic [1:0] {
    flow_dma = 2'h0,
    flow_source = 2'h1,
    flow_dest = 2'h2,
    flow_any = 2'h3
  } dmp_flow_owner_type;

  // Configured field codes
  localparam logic [3:0] DMP_CHAN2_KIND_RESET = 4'h0;
  localparam logic [3:0] DMP_CHAN1_KIND_RESET = 4'h0;
  localparam logic [3:0] DMP_CHAN0_KIND_RESET = 4'h0;
  localparam logic [2:0] DMP_DEPTH_RESET = 3'h1;
  localparam logic [2:0] DMP_BURST_RESET = 3'h1;
  localparam logic [1:0] DMP_FLOW_RESET = 2'h0;
  localparam logic DMP_FIXED_LIST_RESET = 1'h0;
  localparam logic DMP_WRITEBACK_RESET = 1'h0;
  localparam logic DMP_MULTIBLOCK_RESET = 1'h0;
  localparam logic DMP_LOCK_RESET = 1'h0;
  localparam logic DMP_GATHER_RESET = 1'h0;
  localparam logic DMP_SCATTER_RESET = 1'h0;
  localparam logic [2:0] DMP_SRC_WIDTH_RESET = 3'h0;
  localparam logic [2:0] DMP_DST_WIDTH_RESET = 3'h0;

  // Reserved bits 63:44, 31, 27:19 and 7:6
  localparam logic [63:0] DMP_RESERVED_MASK = 64'hFFFF_F000_8FF8_00C0;

  // Avalon-MM response codes
  localparam logic [1:0] DMP_RESP_OKAY = 2'h0;
  localparam logic [1:0] DMP_RESP_DECODE_ERR = 2'h3;

  typedef enum logic [1:0] {
    DMP_IDLE = 2'h1,
    DMP_ACK = 2'h2
  } dmp_state_type;

  function automatic logic [63:0] dmp_field(input logic [7:0] value,
                                            input int lsb);
    dmp_field = 64'(value) << lsb;
  endfunction : dmp_field

endpackage : dmp_pkg

// File: dmp_param_pack.sv
/*
 * Assembles the 64-bit channel parameter word from the configured codes.
 * Assumes nothing of its surroundings; the word is a pure constant.
 */
`timescale 1ns/1ps
module dmp_param_pack import dmp_pkg::*; (
  output logic [63:0] param_word_out // Assembled parameter word
);

  logic [63:0] raw_word;

  always_comb begin
    // RULE2 multiblock kinds
    raw_word = dmp_field(8'(DMP_CHAN2_KIND_RESET), DMP_CHAN2_KIND_LSB)
      | dmp_field(8'(DMP_CHAN1_KIND_RESET), DMP_CHAN1_KIND_LSB)
      | dmp_field(8'(DMP_CHAN0_KIND_RESET), DMP_CHAN0_KIND_LSB)
      // RULE3 buffer depth
      | dmp_field(8'(DMP_DEPTH_RESET), DMP_DEPTH_LSB)
      // RULE4 burst multiple
      | dmp_field(8'(DMP_BURST_RESET), DMP_BURST_LSB)
      // RULE5 flow owner
      | dmp_field(8'(DMP_FLOW_RESET), DMP_FLOW_LSB)
      // RULE6 fixed list pointer
      | dmp_field(8'(DMP_FIXED_LIST_RESET), DMP_FIXED_LIST_BIT)
      // RULE7 control writeback
      | dmp_field(8'(DMP_WRITEBACK_RESET), DMP_WRITEBACK_BIT)
      // RULE8 multiblock support
      | dmp_field(8'(DMP_MULTIBLOCK_RESET), DMP_MULTIBLOCK_BIT)
      // RULE9 lock support
      | dmp_field(8'(DMP_LOCK_RESET), DMP_LOCK_BIT)
      // RULE10 source gather
      | dmp_field(8'(DMP_GATHER_RESET), DMP_GATHER_BIT)
      // RULE11 destination scatter
      | dmp_field(8'(DMP_SCATTER_RESET), DMP_SCATTER_BIT)
      // RULE12 source width
      | dmp_field(8'(DMP_SRC_WIDTH_RESET), DMP_SRC_WIDTH_LSB)
      // RULE13 destination width
      | dmp_field(8'(DMP_DST_WIDTH_RESET), DMP_DST_WIDTH_LSB);
    // RULE14 reserved read zero
    param_word_out = raw_word & ~DMP_RESERVED_MASK;
  end

endmodule : dmp_param_pack

// File: dmp_addr_decode.sv
/*
 * Address decode for the parameter register halves.
 * Assumes word-aligned byte addresses; anything else is unmapped.
 */
`timescale 1ns/1ps
module dmp_addr_decode import dmp_pkg::*; (
  input wire logic [11:0] address_in, // Avalon byte address
  output logic hit_lo_out, // Low word selected
  output logic hit_hi_out, // High word selected
  output logic mapped_out // Any register selected
);

  always_comb begin
    // RULE1 register offset
    hit_lo_out = (address_in == DMP_PARAMS_TWO_LO_OFS);
    hit_hi_out = (address_in == DMP_PARAMS_TWO_HI_OFS);
    mapped_out = hit_lo_out | hit_hi_out;
  end

endmodule : dmp_addr_decode

// File: dmp_param_regs.sv
/*
 * Avalon-MM slave returning the read-only 64-bit channel parameter
 * register of the DMA controller as two 32-bit words.
 * Assumes a master that holds each request until waitrequest is low,
 * byte addressing, and one clock with an asynchronous active-low reset.
 */
// Contract
// RULE1 - Read-only 64-bit parameter register sits at offset 0x3E8.
// RULE2 - 4-bit multiblock kind per channel at 43:40, 39:36, 35:32, default 0.
// RULE3 - Channel 0 buffer depth code in 30:28, default code 1.
// RULE4 - Channel 0 max burst multiple code in 18:16, default code 1.
// RULE5 - Channel 0 flow owner code in 15:14, default DMA (0).
// RULE6 - Bit 13 tells fixed list pointer, default 0.
// RULE7 - Bit 12 tells control writeback support, default 0.
// RULE8 - Bit 11 tells multiblock support, default 0.
// RULE9 - Bit 10 tells lock support, default 0.
// RULE10 - Bit 9 tells source gather support, default 0.
// RULE11 - Bit 8 tells destination scatter support, default 0.
// RULE12 - Fixed source width code in 5:3, default 0.
// RULE13 - Fixed destination width code in 2:0, default 0.
// RULE14 - Reserved bits read zero; writes are ignored.
// RULE15 - Reads return field defaults always, even right after reset.
`timescale 1ns/1ps
module dmp_param_regs import dmp_pkg::*; (
  input wire logic clk_in, // 100 MHz clock
  input wire logic rst_b_in, // Async reset, active low
  input wire logic [11:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [31:0] avs_writedata_in, // Write data, discarded
  output logic [31:0] avs_readdata_out, // Read data, registered
  output logic [1:0] avs_response_out, // Answer code, registered
  output logic avs_waitrequest_out // Low only in answer cycle
);

  dmp_state_type state;
  dmp_state_type next_state;
  logic [31:0] next_readdata;
  logic [1:0] next_response;
  logic [63:0] param_word;
  logic hit_lo;
  logic hit_hi;
  logic mapped;
  logic request;

  dmp_param_pack u_pack (
    .param_word_out(param_word)
  );

  dmp_addr_decode u_decode (
    .address_in(avs_address_in),
    .hit_lo_out(hit_lo),
    .hit_hi_out(hit_hi),
    .mapped_out(mapped)
  );

  assign request = avs_read_in | avs_write_in;
  // Held high outside the answer cycle, so no request slips past decode
  assign avs_waitrequest_out = (state != DMP_ACK);

  always_comb begin
    next_state = state;
    next_readdata = avs_readdata_out;
    next_response = avs_response_out;
    case (state)
      DMP_IDLE: begin
        if (request) begin
          next_state = DMP_ACK;
          next_response = mapped ? DMP_RESP_OKAY : DMP_RESP_DECODE_ERR;
          if (avs_read_in) begin
            // RULE15 constant defaults
            if (hit_lo) begin
              next_readdata = param_word[31:0];
            end else if (hit_hi) begin
              next_readdata = param_word[63:32];
            end else begin
              next_readdata = 32'h0000_0000;
            end
          end
          // RULE14 writes discarded
        end
      end
      DMP_ACK: begin
        // Master still holds its request; it is not taken twice
        next_state = DMP_IDLE;
      end
      // Illegal code: fall back to idle
      default: begin
        next_state = DMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= DMP_IDLE;
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= DMP_RESP_OKAY;
    end else begin
      state <= next_state;
      avs_readdata_out <= next_readdata;
      avs_response_out <= next_response;
    end
  end

  // Helper terms for the checks below
  logic ack_rd_lo;
  logic ack_rd_hi;
  logic ack_rd_bad;
  assign ack_rd_lo = (state == DMP_ACK) && avs_read_in && hit_lo;
  assign ack_rd_hi = (state == DMP_ACK) && avs_read_in && hit_hi;
  assign ack_rd_bad = (state == DMP_ACK) && avs_read_in && !mapped;

  default clocking dmp_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_rule1_answer;
    (state == DMP_IDLE) && avs_read_in && hit_lo
      |=> !avs_waitrequest_out && avs_response_out == DMP_RESP_OKAY
      ##1 avs_waitrequest_out;
  endproperty
  a_rule1_answer: assert property (p_rule1_answer) // RULE1
    else $error("parameter word read not answered in one cycle");

  property p_rule1_unmapped;
    ack_rd_bad |-> avs_readdata_out == 32'h0000_0000
      && avs_response_out == DMP_RESP_DECODE_ERR;
  endproperty
  a_rule1_unmapped: assert property (p_rule1_unmapped) // RULE1
    else $error("unmapped read not answered with decode error");

  property p_rule2_kinds;
    ack_rd_hi |-> avs_readdata_out[11:8] == DMP_CHAN2_KIND_RESET
      && avs_readdata_out[7:4] == DMP_CHAN1_KIND_RESET
      && avs_readdata_out[3:0] == DMP_CHAN0_KIND_RESET;
  endproperty
  a_rule2_kinds: assert property (p_rule2_kinds) // RULE2
    else $error("multiblock kind fields wrong");

  property p_rule3_depth;
    ack_rd_lo |-> avs_readdata_out[30:28] == DMP_DEPTH_RESET;
  endproperty
  a_rule3_depth: assert property (p_rule3_depth) // RULE3
    else $error("buffer depth field wrong");

  property p_rule4_burst;
    ack_rd_lo |-> avs_readdata_out[18:16] == DMP_BURST_RESET;
  endproperty
  a_rule4_burst: assert property (p_rule4_burst) // RULE4
    else $error("burst multiple field wrong");

  property p_rule5_flow;
    ack_rd_lo |-> avs_readdata_out[15:14] == DMP_FLOW_RESET;
  endproperty
  a_rule5_flow: assert property (p_rule5_flow) // RULE5
    else $error("flow owner field wrong");

  property p_rule6_list;
    ack_rd_lo |-> avs_readdata_out[13] == DMP_FIXED_LIST_RESET;
  endproperty
  a_rule6_list: assert property (p_rule6_list) // RULE6
    else $error("fixed list pointer bit wrong");

  property p_rule7_writeback;
    ack_rd_lo |-> avs_readdata_out[12] == DMP_WRITEBACK_RESET;
  endproperty
  a_rule7_writeback: assert property (p_rule7_writeback) // RULE7
    else $error("control writeback bit wrong");

  property p_rule8_multiblock;
    ack_rd_lo |-> avs_readdata_out[11] == DMP_MULTIBLOCK_RESET;
  endproperty
  a_rule8_multiblock: assert property (p_rule8_multiblock) // RULE8
    else $error("multiblock support bit wrong");

  property p_rule9_lock;
    ack_rd_lo |-> avs_readdata_out[10] == DMP_LOCK_RESET;
  endproperty
  a_rule9_lock: assert property (p_rule9_lock) // RULE9
    else $error("lock support bit wrong");

  property p_rule10_gather;
    ack_rd_lo |-> avs_readdata_out[9] == DMP_GATHER_RESET;
  endproperty
  a_rule10_gather: assert property (p_rule10_gather) // RULE10
    else $error("source gather bit wrong");

  property p_rule11_scatter;
    ack_rd_lo |-> avs_readdata_out[8] == DMP_SCATTER_RESET;
  endproperty
  a_rule11_scatter: assert property (p_rule11_scatter) // RULE11
    else $error("destination scatter bit wrong");

  property p_rule12_src_width;
    ack_rd_lo |-> avs_readdata_out[5:3] == DMP_SRC_WIDTH_RESET;
  endproperty
  a_rule12_src_width: assert property (p_rule12_src_width) // RULE12
    else $error("source width field wrong");

  property p_rule13_dst_width;
    ack_rd_lo |-> avs_readdata_out[2:0] == DMP_DST_WIDTH_RESET;
  endproperty
  a_rule13_dst_width: assert property (p_rule13_dst_width) // RULE13
    else $error("destination width field wrong");

  property p_rule14_reserved;
    (ack_rd_lo |-> (avs_readdata_out & DMP_RESERVED_MASK[31:0]) == 32'h0)
      and (ack_rd_hi
        |-> (avs_readdata_out & DMP_RESERVED_MASK[63:32]) == 32'h0);
  endproperty
  a_rule14_reserved: assert property (p_rule14_reserved) // RULE14
    else $error("reserved bits not zero");

  property p_rule14_write;
    (state == DMP_IDLE) && avs_write_in && avs_writedata_in != 32'h0
      |=> !avs_waitrequest_out && $stable(avs_readdata_out);
  endproperty
  a_rule14_write: assert property (p_rule14_write) // RULE14
    else $error("write disturbed read data or was not answered");

  property p_rule15_first_read;
    $rose(rst_b_in) ##1 ((state == DMP_IDLE) && avs_read_in && hit_lo)
      |=> avs_readdata_out == param_word[31:0];
  endproperty
  a_rule15_first_read: assert property (p_rule15_first_read) // RULE15
    else $error("first read after reset lost the field defaults");

  property p_rule1_answer_hi;
    (state == DMP_IDLE) && avs_read_in && hit_hi
      |=> !avs_waitrequest_out && avs_response_out == DMP_RESP_OKAY
      ##1 avs_waitrequest_out;
  endproperty
  a_rule1_answer_hi: assert property (p_rule1_answer_hi) // RULE1
    else $error("high word read not answered in one cycle");

  property p_rule1_one_wait;
    (state == DMP_ACK) |=> avs_waitrequest_out;
  endproperty
  a_rule1_one_wait: assert property (p_rule1_one_wait) // RULE1
    else $error("answer lasted more than one cycle");

  property p_rule1_idle_wait;
    (state == DMP_IDLE) && !avs_read_in && !avs_write_in
      |=> avs_waitrequest_out;
  endproperty
  a_rule1_idle_wait: assert property (p_rule1_idle_wait) // RULE1
    else $error("answer given without a request");

  property p_rule1_bad_write;
    (state == DMP_IDLE) && avs_write_in && !mapped
      |=> !avs_waitrequest_out && avs_response_out == DMP_RESP_DECODE_ERR;
  endproperty
  a_rule1_bad_write: assert property (p_rule1_bad_write) // RULE1
    else $error("unmapped write not answered with decode error");

  property p_rule14_write_okay;
    (state == DMP_IDLE) && avs_write_in && mapped
      |=> !avs_waitrequest_out && avs_response_out == DMP_RESP_OKAY;
  endproperty
  a_rule14_write_okay: assert property (p_rule14_write_okay) // RULE14
    else $error("write to the register not answered with okay");

  property p_rule1_holds_answer;
    (state == DMP_ACK)
      |=> $stable(avs_readdata_out) && $stable(avs_response_out);
  endproperty
  a_rule1_holds_answer: assert property (p_rule1_holds_answer) // RULE1
    else $error("answer changed without a new request");

  property p_rule2_kind_codes;
    ack_rd_hi |-> avs_readdata_out[11:8] <= 4'h8
      && avs_readdata_out[7:4] <= 4'h8 && avs_readdata_out[3:0] <= 4'h8;
  endproperty
  a_rule2_kind_codes: assert property (p_rule2_kind_codes) // RULE2
    else $error("multiblock kind code out of range");

  property p_rule3_depth_code;
    ack_rd_lo |-> avs_readdata_out[30:28] <= 3'h4;
  endproperty
  a_rule3_depth_code: assert property (p_rule3_depth_code) // RULE3
    else $error("buffer depth code out of range");

  property p_rule4_burst_code;
    ack_rd_lo |-> avs_readdata_out[18:16] != 3'h7;
  endproperty
  a_rule4_burst_code: assert property (p_rule4_burst_code) // RULE4
    else $error("burst multiple code reserved");

  property p_rule12_src_code;
    ack_rd_lo |-> avs_readdata_out[5:3] != 3'h7;
  endproperty
  a_rule12_src_code: assert property (p_rule12_src_code) // RULE12
    else $error("source width code reserved");

  property p_rule13_dst_code;
    ack_rd_lo |-> avs_readdata_out[2:0] != 3'h7;
  endproperty
  a_rule13_dst_code: assert property (p_rule13_dst_code) // RULE13
    else $error("destination width code reserved");

endmodule : dmp_param_regs

// File: tb_dma_channel_param_readback.sv
/*
 * Self-checking bench for the channel parameter readback slave.
 * Drives the Avalon-MM port directly and compares with a bench model.
 */
`timescale 1ns/1ps
module tb_dma_channel_param_readback;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] avs_address_in = 12'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [31:0] avs_readdata_out;
  logic [1:0] avs_response_out;
  logic avs_waitrequest_out;
  int n_errors = 0;
  int check_count = 0;
  int waits;
  logic [31:0] seed = 32'h0000_7ED7;
  logic [31:0] rdata;
  logic [1:0] resp;
  logic [63:0] word;
  logic [31:0] model_word [0:1];
  logic [31:0] model_last = 32'h0000_0000;

  dmp_param_regs dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_response_out(avs_response_out),
    .avs_waitrequest_out(avs_waitrequest_out)
  );

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic chk_f(input string nm, input int lsb, input int w,
                       input logic [63:0] e);
    chk(nm, e, (word >> lsb) & ((64'h1 << w) - 64'h1));
  endtask : chk_f

  // Request held until waitrequest is sampled low at a rising edge
  task automatic xfer(input logic rd, input logic [11:0] addr,
                      input logic [31:0] wd);
    int n;
    n = 0;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    avs_address_in <= addr;
    avs_writedata_in <= wd;
    // Values read right after the edge are those sampled at it
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0);
    rdata = avs_readdata_out;
    resp = avs_response_out;
    waits = n - 1;
  endtask : xfer

  task automatic access(input logic rd, input logic [11:0] addr,
                        input logic [31:0] wd);
    logic mapped;
    mapped = (addr == 12'h3E8) || (addr == 12'h3EC);
    xfer(rd, addr, wd);
    // Writes leave the last read data standing
    if (rd) begin
      model_last = mapped ? model_word[addr[2]] : 32'h0000_0000;
    end
    chk("response", mapped ? 64'h0 : 64'h3, 64'(resp));
    chk("readdata", 64'(model_last), 64'(rdata));
    chk("wait_cycles", 64'h1, 64'(waits));
  endtask : access

  task automatic idle;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    avs_address_in <= seed[11:0];
  endtask : idle

  task automatic read_word;
    access(1'b1, 12'h3E8, 32'h0000_0000);
    word[31:0] = rdata;
    access(1'b1, 12'h3EC, 32'h0000_0000);
    word[63:32] = rdata;
  endtask : read_word

  task automatic conclude;
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Whole run is a few hundred cycles; this is ample margin
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    model_word[0] = (32'h1 << 28) | (32'h1 << 16);
    model_word[1] = 32'h0000_0000;
    repeat (12) begin
      @(negedge clk_in);
      chk("reset_wait", 64'h1, 64'(avs_waitrequest_out));
      chk("reset_data", 64'h0, 64'(avs_readdata_out));
    end
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    read_word();
    chk_f("chan2_kind", 40, 4, 64'h0);
    chk_f("chan1_kind", 36, 4, 64'h0);
    chk_f("chan0_kind", 32, 4, 64'h0);
    chk_f("depth", 28, 3, 64'h1);
    chk_f("burst", 16, 3, 64'h1);
    chk_f("flow", 14, 2, 64'h0);
    chk_f("fixed_list", 13, 1, 64'h0);
    chk_f("writeback", 12, 1, 64'h0);
    chk_f("multiblock", 11, 1, 64'h0);
    chk_f("lock", 10, 1, 64'h0);
    chk_f("gather", 9, 1, 64'h0);
    chk_f("scatter", 8, 1, 64'h0);
    chk_f("src_width", 3, 3, 64'h0);
    chk_f("dst_width", 0, 3, 64'h0);
    chk("reserved", 64'h0, word & 64'hFFFF_F000_8FF8_00C0);
    access(1'b0, 12'h3E8, 32'hFFFF_FFFF);
    access(1'b0, 12'h3EC, 32'hFFFF_FFFF);
    read_word();
    // Mixed traffic, some back to back, some with gaps
    repeat (60) begin
      seed = xorshift(seed);
      case (seed[1:0])
        2'h0: access(seed[2], 12'h3E8, seed);
        2'h1: access(seed[2], 12'h3EC, seed);
        default: access(seed[2], seed[15:4], seed);
      endcase
      if (seed[3]) begin
        idle();
        @(posedge clk_in);
      end
    end
    idle();
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (3) begin
      @(negedge clk_in);
      chk("mid_reset_wait", 64'h1, 64'(avs_waitrequest_out));
      chk("mid_reset_data", 64'h0, 64'(avs_readdata_out));
    end
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    model_last = 32'h0000_0000;
    @(posedge clk_in);
    read_word();
    idle();
    @(posedge clk_in);
    conclude();
  end
endmodule : tb_dma_channel_param_readback
